// ---- gpio_clkout_extint_pins.sv ----
/*
  Pin group: shared half-rate clock / line two pin, four lines that are
  GPIO and edge interrupts at once, APB register slave, interrupt line.
  Assumes pclk is the core clock; pins arrive asynchronously.
*/
// Implementation choices: the address map and the APB interface to the registers.
//
// Behaviour
// - Clock mode drives half core rate clock
// - Pin shared with line two, clock default
// - Enable bit zero stops the clock
// - Enable bit one toggles; default one
// - Lines four..seven are GPIO and interrupts
// - Edge interrupts, per-line polarity bit
// - GPIO interrupt enables also gate interrupts
`timescale 1ns/100ps
`default_nettype none
`include "gpio_pins_defines.svh"

module gpio_clkout_extint_pins
  import gpio_pins_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [`ADDR_W-1:0] paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire logic               half_rate_clock_out_i,
  output var  logic               half_rate_clock_out_o,
  output var  logic               half_rate_clock_out_oe,
  input  wire line_quad_t         line_i,
  output var  line_quad_t         line_o,
  output var  line_quad_t         line_oe,
  output var  irq_quad_t          ext_irq,
  output var  logic               irq
);

  state_t      st_ff;
  state_t      nxt_st;
  logic [31:0] rd;
  logic        hit;
  logic        acc;
  logic        wr;
  logic [3:0]  w1c;
  logic [7:0]  agree;
  logic [7:0]  rise;
  logic [7:0]  fall;
  logic [3:0]  edge4;

  always_comb begin
    nxt_st = st_ff;
    rd     = 32'h0000_0000;
    hit    = 1'b1;
    w1c    = 4'h0;
    acc    = psel & penable;
    wr     = acc & st_ff.pready & pwrite;

    // Three-stage synchroniser; a level counts once stages two and three agree
    nxt_st.sync1 = {line_i, 1'b0, half_rate_clock_out_i, 2'b00} & `LINE_IMPL_MASK;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    agree        = ~(st_ff.sync2 ^ st_ff.sync3);
    nxt_st.filt  = (agree & st_ff.sync3) | (~agree & st_ff.filt);

    rise  = nxt_st.filt & ~st_ff.filt;
    fall  = ~nxt_st.filt & st_ff.filt;
    edge4 = (rise[7:4] & ~st_ff.pol) | (fall[7:4] & st_ff.pol);
    nxt_st.pulse = edge4 & st_ff.gen;

    // Register decode
    if (paddr == `OFS_MEMIF_GLOBAL) begin
      rd[`BIT_HALF_CLK_EN] = st_ff.clk_en;
      if (wr) begin
        nxt_st.clk_en = pwdata[`BIT_HALF_CLK_EN];
      end
    end else if (paddr == `OFS_PIN_FUNCTION) begin
      rd[`BIT_FN_CLOCK] = st_ff.fn_clock;
      if (wr) begin
        nxt_st.fn_clock = pwdata[`BIT_FN_CLOCK];
      end
    end else if (paddr == `OFS_GPIO_DIR) begin
      rd[7:0] = st_ff.dir;
      if (wr) begin
        nxt_st.dir = pwdata[7:0] & `LINE_IMPL_MASK;
      end
    end else if (paddr == `OFS_GPIO_OUT) begin
      rd[7:0] = st_ff.dout;
      if (wr) begin
        nxt_st.dout = pwdata[7:0] & `LINE_IMPL_MASK;
      end
    end else if (paddr == `OFS_GPIO_IN) begin
      rd[7:0] = st_ff.filt;
    end else if (paddr == `OFS_EXT_POLARITY) begin
      rd[3:0] = st_ff.pol;
      if (wr) begin
        nxt_st.pol = pwdata[3:0];
      end
    end else if (paddr == `OFS_GPIO_IRQ_EN) begin
      rd[3:0] = st_ff.gen;
      if (wr) begin
        nxt_st.gen = pwdata[3:0];
      end
    end else if (paddr == `OFS_IRQ_STATUS) begin
      rd[3:0] = st_ff.stat;
      if (wr) begin
        w1c = pwdata[3:0];
      end
    end else if (paddr == `OFS_IRQ_MASK) begin
      rd[3:0] = st_ff.mask;
      if (wr) begin
        nxt_st.mask = pwdata[3:0];
      end
    end else begin
      hit = 1'b0;
    end

    // One wait state: answer registered in the first access cycle
    nxt_st.pready = acc & ~st_ff.pready;
    if (acc & ~st_ff.pready) begin
      nxt_st.prdata  = pwrite ? 32'h0000_0000 : rd;
      nxt_st.pslverr = ~hit;
    end

    // New events win over a clear in the same cycle
    nxt_st.stat = (st_ff.stat & ~w1c) | nxt_st.pulse;
    nxt_st.irq  = |(nxt_st.stat & nxt_st.mask);

    // Half-rate clock, held low while stopped
    nxt_st.clk_tgl = st_ff.clk_en & ~st_ff.clk_tgl;
    if (st_ff.fn_clock) begin
      nxt_st.pin2_o  = nxt_st.clk_tgl;
      nxt_st.pin2_oe = 1'b1;
    end else begin
      nxt_st.pin2_o  = st_ff.dout[`LINE_TWO];
      nxt_st.pin2_oe = st_ff.dir[`LINE_TWO];
    end

    nxt_st.lo  = st_ff.dout[7:4];
    nxt_st.loe = st_ff.dir[7:4];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.clk_en   <= `RST_HALF_CLK_EN;
      st_ff.fn_clock <= `RST_FN_CLOCK;
      st_ff.gen      <= `RST_GPIO_IRQ_EN;
      st_ff.pin2_oe  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata                 = st_ff.prdata;
  assign pready                 = st_ff.pready;
  assign pslverr                = st_ff.pslverr;
  assign half_rate_clock_out_o  = st_ff.pin2_o;
  assign half_rate_clock_out_oe = st_ff.pin2_oe;
  assign line_o                 = st_ff.lo;
  assign line_oe                = st_ff.loe;
  assign ext_irq                = st_ff.pulse;
  assign irq                    = st_ff.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_clock_follows_toggle: assert property (
    (st_ff.fn_clock && st_ff.clk_en) |=> (half_rate_clock_out_o == !$past(st_ff.clk_tgl)
      && half_rate_clock_out_oe))
    else $error("clock pin does not follow half-rate toggle");

  chk_gpio_two_mode: assert property (
    !st_ff.fn_clock |=> (half_rate_clock_out_o == $past(st_ff.dout[`LINE_TWO])
      && half_rate_clock_out_oe == $past(st_ff.dir[`LINE_TWO])))
    else $error("line two not driven from gpio registers");

  chk_clock_stopped: assert property (
    (st_ff.fn_clock && !st_ff.clk_en)[*2] |=> !half_rate_clock_out_o)
    else $error("clock pin not held low while disabled");

  chk_clock_period: assert property (
    (st_ff.fn_clock && st_ff.clk_en)[*4] |-> (half_rate_clock_out_o != $past(half_rate_clock_out_o)
      && half_rate_clock_out_o == $past(half_rate_clock_out_o, 2)))
    else $error("clock pin not at half rate");

  chk_line_drive: assert property (
    ##1 (line_oe == $past(st_ff.dir[7:4]) && line_o == $past(st_ff.dout[7:4])))
    else $error("interrupt lines not driven from gpio registers");

  chk_edge_polarity: assert property (
    ext_irq[0] |-> ($past(st_ff.pol[0]) ? $fell(st_ff.filt[`LINE_FOUR])
      : $rose(st_ff.filt[`LINE_FOUR])))
    else $error("interrupt pulse on wrong edge");

  chk_gpio_enable: assert property (
    !$past(st_ff.gen[3]) |-> !ext_irq[3])
    else $error("interrupt raised on disabled line");

  chk_pulse_single: assert property (
    ext_irq[1] |=> !ext_irq[1] ##1 !ext_irq[1])
    else $error("interrupt pulse longer than one cycle");

  chk_sticky_irq: assert property (
    (st_ff.pulse != 4'h0) |-> (st_ff.stat & st_ff.pulse) == st_ff.pulse)
    else $error("status did not capture interrupt");

  // Bus handshake
  chk_pready_single: assert property (
    pready
    |=> !pready)
    else $error("pready high for more than one cycle");

  chk_pready_setup: assert property (
    (psel && !penable)
    |=> !pready)
    else $error("pready raised after setup cycle");

  chk_pready_answer: assert property (
    (psel && penable && !pready)
    |=> pready)
    else $error("pready missing after first access cycle");

  chk_ready_low_idle: assert property (
    !psel
    |=> !pready)
    else $error("pready raised without a transfer");

  chk_write_reads_zero: assert property (
    (pready && $past(pwrite))
    |-> (prdata == 32'h0000_0000))
    else $error("read data not zero on write");

  chk_unmapped_error: assert property (
    (pready && ($past(paddr) > `OFS_IRQ_MASK))
    |-> pslverr)
    else $error("no error on unmapped address");

  chk_mapped_ok: assert property (
    (pready && ($past(paddr) == `OFS_GPIO_IN))
    |-> !pslverr)
    else $error("error on mapped address");

  chk_gpio_in_read: assert property (
    (pready && !$past(pwrite) && ($past(paddr) == `OFS_GPIO_IN))
    |-> (prdata == {24'h00_0000, $past(st_ff.filt)}))
    else $error("input register does not show synced pins");

  // Register writes
  chk_enable_write: assert property (
    (psel && penable && pready && pwrite && (paddr == `OFS_MEMIF_GLOBAL))
    |=> (st_ff.clk_en == $past(pwdata[`BIT_HALF_CLK_EN])))
    else $error("clock enable write lost");

  chk_function_write: assert property (
    (psel && penable && pready && pwrite && (paddr == `OFS_PIN_FUNCTION))
    |=> (st_ff.fn_clock == $past(pwdata[`BIT_FN_CLOCK])))
    else $error("pin function write lost");

  chk_polarity_write: assert property (
    (psel && penable && pready && pwrite && (paddr == `OFS_EXT_POLARITY))
    |=> (st_ff.pol == $past(pwdata[3:0])))
    else $error("polarity write lost");

  chk_gen_write: assert property (
    (psel && penable && pready && pwrite && (paddr == `OFS_GPIO_IRQ_EN))
    |=> (st_ff.gen == $past(pwdata[3:0])))
    else $error("interrupt enable write lost");

  chk_mask_write: assert property (
    (psel && penable && pready && pwrite && (paddr == `OFS_IRQ_MASK))
    |=> (st_ff.mask == $past(pwdata[3:0])))
    else $error("mask write lost");

  chk_dir_bits: assert property (
    (st_ff.dir & ~`LINE_IMPL_MASK) == 8'h00
    )
    else $error("direction bit set on missing line");

  chk_dout_bits: assert property (
    (st_ff.dout & ~`LINE_IMPL_MASK) == 8'h00
    )
    else $error("output bit set on missing line");

  // Status and interrupt line
  chk_status_clear: assert property (
    (psel && penable && pready && pwrite && (paddr == `OFS_IRQ_STATUS))
    |=> ((st_ff.stat & $past(pwdata[3:0]) & ~st_ff.pulse) == 4'h0))
    else $error("status bit not cleared by write of one");

  chk_status_sticky: assert property (
    !(psel && penable && pready && pwrite && (paddr == `OFS_IRQ_STATUS))
    |=> (($past(st_ff.stat) & ~st_ff.stat) == 4'h0))
    else $error("status bit dropped without a clear");

  chk_irq_level: assert property (
    irq == (|(st_ff.stat & st_ff.mask))
    )
    else $error("interrupt line does not follow status and mask");

  // Clock pin
  chk_clock_oe_mode: assert property (
    st_ff.fn_clock
    |=> half_rate_clock_out_oe)
    else $error("clock pin not driven in clock mode");

  chk_toggle_stopped: assert property (
    !st_ff.clk_en
    |=> !st_ff.clk_tgl)
    else $error("half-rate toggle runs while disabled");

  chk_toggle_runs: assert property (
    st_ff.clk_en
    |=> (st_ff.clk_tgl != $past(st_ff.clk_tgl)))
    else $error("half-rate toggle stuck while enabled");

  // Synchroniser and edge detection
  chk_sync_chain: assert property (
    1'b1
    |=> (st_ff.sync2 == $past(st_ff.sync1) && st_ff.sync3 == $past(st_ff.sync2)))
    else $error("synchroniser stages do not shift");

  chk_filter_agree: assert property (
    $changed(st_ff.filt)
    |-> $past(st_ff.sync2 == st_ff.sync3))
    else $error("filtered level changed without agreement");

  chk_filter_value: assert property (
    $changed(st_ff.filt)
    |-> (st_ff.filt == $past(st_ff.sync3)))
    else $error("filtered level not taken from last stage");

  chk_pulse_needs_edge: assert property (
    $stable(st_ff.filt[7:4])
    |-> (st_ff.pulse == 4'h0))
    else $error("interrupt pulse without an edge");

  chk_gpio_enable_four: assert property (
    !$past(st_ff.gen[0])
    |-> !ext_irq[0])
    else $error("interrupt raised on disabled line four");

endmodule // gpio_clkout_extint_pins

`default_nettype wire

// ---- gpio_pins_defines.svh ----
/*
  Register offsets, field positions, reset values and masks of the
  pin group block. Assumes a byte-addressed APB with 32-bit words.
*/
`ifndef GPIO_PINS_DEFINES_SVH
`define GPIO_PINS_DEFINES_SVH

`define ADDR_W              12
`define OFS_MEMIF_GLOBAL    12'h000
`define OFS_PIN_FUNCTION    12'h004
`define OFS_GPIO_DIR        12'h008
`define OFS_GPIO_OUT        12'h00C
`define OFS_GPIO_IN         12'h010
`define OFS_EXT_POLARITY    12'h014
`define OFS_GPIO_IRQ_EN     12'h018
`define OFS_IRQ_STATUS      12'h01C
`define OFS_IRQ_MASK        12'h020

`define BIT_HALF_CLK_EN     0
`define BIT_FN_CLOCK        0
`define LINE_TWO            2
`define LINE_FOUR           4

`define RST_HALF_CLK_EN     1'b1
`define RST_FN_CLOCK        1'b1
`define RST_GPIO_IRQ_EN     4'hF
`define LINE_IMPL_MASK      8'hF4

`endif

// ---- gpio_pins_pkg.sv ----
/*
  Types of the pin group block: pin groups, interrupt pulses and the
  block state. Assumes gpio_pins_defines.svh is compiled alongside.
*/
`default_nettype none

package gpio_pins_pkg;

  typedef struct packed {
    logic gpio_line_seven;
    logic gpio_line_six;
    logic gpio_line_five;
    logic gpio_line_four;
  } line_quad_t;

  typedef struct packed {
    logic ext_irq_seven;
    logic ext_irq_six;
    logic ext_irq_five;
    logic ext_irq_four;
  } irq_quad_t;

  typedef struct packed {
    logic        clk_en;
    logic        fn_clock;
    logic [7:0]  dir;
    logic [7:0]  dout;
    logic [3:0]  pol;
    logic [3:0]  gen;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  sync3;
    logic [7:0]  filt;
    logic        clk_tgl;
    logic        pin2_o;
    logic        pin2_oe;
    logic [3:0]  lo;
    logic [3:0]  loe;
    logic [3:0]  pulse;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } state_t;

endpackage

`default_nettype wire

// ---- tb_gpio_clkout_extint_pins.sv ----
/*
  Self-checking bench of the pin group: APB register access, clock pin,
  GPIO lines and edge interrupts. Assumes the package and defines header.
*/
`include "gpio_pins_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import gpio_pins_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, rv;
  logic               cko, ckoe, cki, ck_drv, irq, ev;
  logic [3:0]         drv, irqv;
  line_quad_t         li, lo, loe;
  irq_quad_t          ei;
  int                 err_total, total_checks;

  // Wire level of the two-way pins
  assign cki  = ckoe ? cko : ck_drv;
  assign li   = line_quad_t'((lo & loe) | (drv & ~loe));
  assign irqv = ei;

  gpio_clkout_extint_pins u_gpio_clkout_extint_pins (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .half_rate_clock_out_i(cki), .half_rate_clock_out_o(cko),
    .half_rate_clock_out_oe(ckoe), .line_i(li), .line_o(lo), .line_oe(loe),
    .ext_irq(ei), .irq(irq));

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      #1;
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Setup, access until pready, taken at the following edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      final_report;
    end
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(0, a, 32'h0);
    chk(nm, e, rv);
  endtask

  // Drive one line, count cycles of its interrupt pulse
  task automatic edge_at(input int k, input logic lv, input logic [31:0] e);
    int n;
    @(posedge pclk);
    drv[k] <= lv;
    n = 0;
    repeat (8) begin
      tick(1);
      if (irqv[k] === 1'b1) n++;
    end
    chk("pulse cycles", e, n);
  endtask

  task automatic t_reset;
    rd(`OFS_MEMIF_GLOBAL, 32'h1, "clock enable");
    rd(`OFS_PIN_FUNCTION, 32'h1, "pin function");
    rd(`OFS_GPIO_IRQ_EN, 32'hF, "irq enable");
    rd(`OFS_IRQ_MASK, 32'h0, "irq mask");
    chk("clock pin oe", 32'h1, ckoe);
  endtask

  task automatic t_clock;
    logic a;
    a = cko;
    tick(1);
    chk("clock toggle", {31'h0, !a}, cko);
    tick(1);
    chk("clock toggle", {31'h0, a}, cko);
    wr(`OFS_MEMIF_GLOBAL, 32'h0);
    repeat (4) begin
      chk("clock stopped", 32'h0, cko);
      tick(1);
    end
    wr(`OFS_MEMIF_GLOBAL, 32'h1);
    a = cko;
    tick(1);
    chk("clock restart", {31'h0, !a}, cko);
  endtask

  task automatic t_gpio;
    wr(`OFS_PIN_FUNCTION, 32'h0);
    wr(`OFS_GPIO_DIR, 32'h4);
    wr(`OFS_GPIO_OUT, 32'h4);
    chk("line two out", 32'h1, cko);
    chk("line two oe", 32'h1, ckoe);
    wr(`OFS_GPIO_DIR, 32'h0);
    chk("line two oe", 32'h0, ckoe);
    ck_drv <= 1;
    wr(`OFS_GPIO_DIR, 32'hF0);
    wr(`OFS_GPIO_OUT, 32'hA0);
    chk("line out", 32'hA, lo);
    chk("line oe", 32'hF, loe);
    tick(4);
    rd(`OFS_GPIO_IN, 32'hA4, "gpio in");
    wr(`OFS_GPIO_DIR, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'hA, "status from outputs");
    wr(`OFS_IRQ_STATUS, 32'hF);
  endtask

  task automatic t_irq;
    wr(`OFS_IRQ_MASK, 32'hF);
    wr(`OFS_EXT_POLARITY, 32'h2);
    edge_at(0, 1, 32'h1);
    chk("irq level", 32'h1, irq);
    rd(`OFS_IRQ_STATUS, 32'h1, "status four");
    wr(`OFS_IRQ_STATUS, 32'h1);
    chk("irq cleared", 32'h0, irq);
    edge_at(1, 1, 32'h0);
    edge_at(1, 0, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'hF);
    wr(`OFS_IRQ_MASK, 32'h0);
    edge_at(2, 1, 32'h1);
    chk("irq masked", 32'h0, irq);
    rd(`OFS_IRQ_STATUS, 32'h4, "status six");
    wr(`OFS_IRQ_STATUS, 32'hF);
    edge_at(0, 0, 32'h0);
    wr(`OFS_GPIO_IRQ_EN, 32'hE);
    edge_at(0, 1, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'h0, "status disabled");
    apb(0, 12'h024, 32'h0);
    chk("unmapped data", 32'h0, rv);
    chk("unmapped error", 32'h1, ev);
  endtask

  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = 32'h0;
    ck_drv = 0;
    drv = 4'h0;
    err_total = 0;
    total_checks = 0;
    tick(8);
    presetn <= 1;
    tick(1);
    t_reset;
    t_clock;
    t_gpio;
    t_irq;
    final_report;
  end
endmodule // testbench

`default_nettype wire
